// File: rtl/pitc_map.vh
/*
 Register offsets, field positions, reset values and vector constants of the
 priority interrupt and trap controller. Assumes byte addressing on AHB-Lite.
*/
`ifndef PITC_MAP_VH
`define PITC_MAP_VH
`define PITC_SRC_BASE      12'h000
`define PITC_TRAP_FLAG     12'h100
`define PITC_TRAP_CLEAR    12'h104
`define PITC_CPU_LEVEL     12'h108
`define PITC_ACK_STATUS    12'h10C
`define PITC_IRQ_STATUS    12'h110
`define PITC_IRQ_MASK      12'h114
`define PITC_BIT_REQ       7
`define PITC_BIT_EN        6
`define PITC_PRIORITY_LEVEL_FIELD_HI       5
`define PITC_PRIORITY_LEVEL_FIELD_LO       2
`define PITC_GROUP_LEVEL_FIELD_HI       1
`define PITC_GROUP_LEVEL_FIELD_LO       0
`define PITC_CTRL_RESET    8'h00
`define PITC_LEVEL_MAX     4'hF
`define PITC_VEC_SHIFT     2
`define PITC_TRAP_WIDTH    8
`endif

// File: rtl/pitc_arbiter.v
/*
 Combinational arbiter over all source control bytes.
 Assumes control bytes packed, source 0 in the low byte.
*/
`timescale 1ns/1ps
`default_nettype none
`include "pitc_map.vh"
module pitc_arbiter #(
   parameter N = 35
) (
   input  wire [N*8-1:0] ctrl,
   output reg            found,
   output reg  [5:0]     index,
   output reg  [3:0]     level
);
   integer   i;
   reg [5:0] best;
   reg [7:0] c;
   always @* begin
      found = 1'b0;
      index = 6'h00;
      level = 4'h0;
      best  = 6'h00;
      c     = 8'h00;
      for (i = 0; i < N; i = i + 1) begin
         c = ctrl[i*8 +: 8];
         // Rank is level then group, packed as one six-bit key
         if (c[`PITC_BIT_REQ] && c[`PITC_BIT_EN] && (!found || c[5:0] > best)) begin
            found = 1'b1;
            best  = c[5:0];
            index = i[5:0];
            level = c[`PITC_PRIORITY_LEVEL_FIELD_HI:`PITC_PRIORITY_LEVEL_FIELD_LO];
         end
      end
   end
endmodule
`default_nettype wire

// File: rtl/pitc_trap_unit.v
/*
 Hardware trap flag register and trap class selection.
 Assumes trap events are one-cycle pulses from the same clock.
*/
`timescale 1ns/1ps
`default_nettype none
`include "pitc_map.vh"
module pitc_trap_unit (
   input  wire       hclk,
   input  wire       hresetn,
   input  wire [7:0] trap_event,
   input  wire [7:0] trap_clear,
   output reg  [7:0] trap_flag,
   output wire       trap_pending,
   output reg  [6:0] trap_number,
   output reg  [1:0] trap_class
);
   assign trap_pending = |trap_event;
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         trap_flag <= 8'h00;
      end else begin
         trap_flag <= (trap_flag & ~trap_clear) | trap_event;
      end
   end
   // Class A traps own vectors, class B traps share one
   always @* begin
      trap_number = 7'h00;
      trap_class  = 2'h0;
      if (trap_event[0]) begin
         trap_number = 7'h02;
         trap_class  = 2'h2;
      end else if (trap_event[1]) begin
         trap_number = 7'h04;
         trap_class  = 2'h2;
      end else if (trap_event[2]) begin
         trap_number = 7'h06;
         trap_class  = 2'h2;
      end else if (|trap_event[7:3]) begin
         trap_number = 7'h0A;
         trap_class  = 2'h1;
      end
   end
endmodule
`default_nettype wire

// File: rtl/pitc_top.v
/*
 Priority interrupt and trap controller with AHB-Lite register access.
 Assumes source requests and trap events are single-cycle pulses on hclk,
 and the CPU pulses service_done at the end of each service routine.
*/
// Local design decisions: the AHB-Lite register port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
`include "pitc_map.vh"
module pitc_top #(
   parameter N = 35
) (
   input  wire        hclk,
   input  wire        hresetn,
   input  wire        hsel,
   input  wire [11:0] haddr,
   input  wire [1:0]  htrans,
   input  wire        hwrite,
   input  wire [2:0]  hsize,
   input  wire [31:0] hwdata,
   input  wire        hready,
   output reg  [31:0] hrdata,
   output reg         hreadyout,
   output reg         hresp,
   input  wire [N-1:0] src_request,
   input  wire [7:0]  trap_event,
   input  wire        service_done,
   output reg         cpu_take,
   output reg  [6:0]  cpu_trap_number,
   output reg  [8:0]  cpu_vector,
   output reg  [3:0]  cpu_level,
   output reg         irq
);
   ////////////////////////////////////////////////////////////////////////////
   // Fixed source trap numbers, window order
   function [6:0] src_trap;
      input [5:0] i;
      begin
         if (i <= 6'd7)       src_trap = 7'h35 + {1'b0, i};
         else if (i <= 6'd10) src_trap = 7'h44 + {1'b0, i} - 7'h08;
         else if (i <= 6'd12) src_trap = 7'h20 + {1'b0, i} - 7'h0B;
         else if (i <= 6'd14) src_trap = 7'h3D + {1'b0, i} - 7'h0D;
         else if (i <= 6'd23) src_trap = 7'h22 + {1'b0, i} - 7'h0F;
         else if (i == 6'd24) src_trap = 7'h47;
         else if (i <= 6'd29) src_trap = 7'h2B + {1'b0, i} - 7'h19;
         else if (i == 6'd30) src_trap = 7'h3F;
         else                 src_trap = 7'h40 + {1'b0, i} - 7'h1F;
      end
   endfunction
   ////////////////////////////////////////////////////////////////////////////
   reg  [7:0]   ctrl [0:N-1];
   wire [N*8-1:0] ctrl_flat;
   wire         arb_found;
   wire [5:0]   arb_index;
   wire [3:0]   arb_level;
   wire [7:0]   trap_flag;
   wire         trap_pending;
   wire [6:0]   trap_number;
   wire [1:0]   trap_class;
   reg  [7:0]   trap_clear;
   reg  [7:0]   trap_hold;
   reg  [7:0]   taken_mask;
   wire [7:0]   trap_in;
   reg  [1:0]   active_class;
   reg  [1:0]   next_class;
   reg  [3:0]   saved_level;
   reg  [1:0]   irq_status;
   reg  [1:0]   irq_mask;
   reg          ph_write;
   reg  [11:0]  ph_addr;
   reg          ph_valid;
   reg          take_irq;
   reg          take_trap;
   integer      k;
   genvar       g;
   generate
      for (g = 0; g < N; g = g + 1) begin : pack
         assign ctrl_flat[g*8 +: 8] = ctrl[g];
      end
   endgenerate
   pitc_arbiter #(.N(N)) u_arb (
      .ctrl  (ctrl_flat),
      .found (arb_found),
      .index (arb_index),
      .level (arb_level)
   );
   pitc_trap_unit u_trap (
      .hclk         (hclk),
      .hresetn      (hresetn),
      .trap_event   (trap_in),
      .trap_clear   (trap_clear),
      .trap_flag    (trap_flag),
      .trap_pending (trap_pending),
      .trap_number  (trap_number),
      .trap_class   (trap_class)
   );
   ////////////////////////////////////////////////////////////////////////////
   // Traps not taken wait here until the running service ends
   assign trap_in = trap_event | trap_hold;
   always @* begin
      taken_mask = 8'hF8;
      if (trap_in[0])
         taken_mask = 8'h01;
      else if (trap_in[1])
         taken_mask = 8'h02;
      else if (trap_in[2])
         taken_mask = 8'h04;
   end
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         trap_hold <= 8'h00;
      end else if (take_trap) begin
         trap_hold <= trap_in & ~taken_mask;
      end else begin
         trap_hold <= trap_in;
      end
   end
   // Service decision
   always @* begin
      take_trap = trap_pending && (trap_class > active_class);
      take_irq  = !take_trap && (active_class == 2'h0) && arb_found && (arb_level > cpu_level);
   end
   // Trap classes nest one deep; a done pulse returns to normal flow
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         active_class    <= 2'h0;
         saved_level     <= 4'h0;
         cpu_level       <= `PITC_LEVEL_MAX;
         cpu_take        <= 1'b0;
         cpu_trap_number <= 7'h00;
         cpu_vector      <= 9'h000;
      end else begin
         cpu_take <= take_trap | take_irq;
         if (take_trap) begin
            active_class    <= trap_class;
            if (active_class == 2'h0)
               saved_level  <= cpu_level;
            cpu_level       <= `PITC_LEVEL_MAX;
            cpu_trap_number <= trap_number;
            cpu_vector      <= {trap_number, 2'b00};
         end else if (take_irq) begin
            cpu_level       <= arb_level;
            cpu_trap_number <= src_trap(arb_index);
            cpu_vector      <= {src_trap(arb_index), 2'b00};
         end else if (service_done && active_class != 2'h0) begin
            active_class    <= 2'h0;
            cpu_level       <= saved_level;
         end else if (ph_valid && ph_write && ph_addr == `PITC_CPU_LEVEL) begin
            cpu_level       <= hwdata[3:0];
         end
      end
   end
   ////////////////////////////////////////////////////////////////////////////
   // AHB-Lite slave, zero wait states
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ph_valid  <= 1'b0;
         ph_write  <= 1'b0;
         ph_addr   <= 12'h000;
         hreadyout <= 1'b1;
         hresp     <= 1'b0;
      end else begin
         ph_valid <= hsel && hready && htrans[1];
         ph_write <= hwrite;
         ph_addr  <= haddr;
      end
   end
   always @* begin
      trap_clear = 8'h00;
      if (ph_valid && ph_write && ph_addr == `PITC_TRAP_CLEAR)
         trap_clear = hwdata[7:0];
   end
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         for (k = 0; k < N; k = k + 1)
            ctrl[k] <= `PITC_CTRL_RESET;
      end else begin
         for (k = 0; k < N; k = k + 1) begin
            if (ph_valid && ph_write && ph_addr == (`PITC_SRC_BASE + k * 4))
               ctrl[k] <= hwdata[7:0];
            if (src_request[k])
               ctrl[k][`PITC_BIT_REQ] <= 1'b1;
            else if (take_irq && arb_index == k)
               ctrl[k][`PITC_BIT_REQ] <= 1'b0;
         end
      end
   end
   // Status: bit 0 trap taken, bit 1 interrupt granted; write one to clear
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         irq_status <= 2'h0;
         irq_mask   <= 2'h0;
         irq        <= 1'b0;
      end else begin
         if (ph_valid && ph_write && ph_addr == `PITC_IRQ_MASK)
            irq_mask <= hwdata[1:0];
         irq_status <= (irq_status & ~((ph_valid && ph_write && ph_addr == `PITC_IRQ_STATUS) ? hwdata[1:0] : 2'h0))
                       | {take_irq, take_trap};
         irq        <= |(irq_status & irq_mask);
      end
   end
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hrdata <= 32'h00000000;
      end else if (hsel && hready && htrans[1] && !hwrite) begin
         if (haddr < N * 4)
            hrdata <= {24'h000000, ctrl[haddr[7:2]]};
         else if (haddr == `PITC_TRAP_FLAG)
            hrdata <= {24'h000000, trap_flag};
         else if (haddr == `PITC_CPU_LEVEL)
            hrdata <= {28'h0000000, cpu_level};
         else if (haddr == `PITC_ACK_STATUS)
            hrdata <= {22'h000000, active_class, 1'b0, cpu_trap_number};
         else if (haddr == `PITC_IRQ_STATUS)
            hrdata <= {30'h00000000, irq_status};
         else if (haddr == `PITC_IRQ_MASK)
            hrdata <= {30'h00000000, irq_mask};
         else
            hrdata <= 32'h00000000;
      end
   end
endmodule
`default_nettype wire

// File: bench/pitc_top_props.sv
/* Port checker for pitc_top.
 Bound into pitc_top; sees only its ports. */
`timescale 1ns/1ps
`default_nettype none
module pitc_top_props (
   input wire logic        hclk,
   input wire logic        hresetn,
   input wire logic        hsel,
   input wire logic [11:0] haddr,
   input wire logic [1:0]  htrans,
   input wire logic        hwrite,
   input wire logic        hready,
   input wire logic [31:0] hrdata,
   input wire logic        hreadyout,
   input wire logic        hresp,
   input wire logic [7:0]  trap_event,
   input wire logic        service_done,
   input wire logic        cpu_take,
   input wire logic [6:0]  cpu_trap_number,
   input wire logic [8:0]  cpu_vector,
   input wire logic [3:0]  cpu_level
);
default clocking @(posedge hclk); endclocking
default disable iff (!hresetn);
////////////////////////////////////////////////////////////
bus_okay_a: assert property (hresp == 1'b0 && hreadyout == 1'b1)
   else $error("bus answer not OKAY or not ready");
upper_zero_a: assert property (hsel && hready && htrans[1] && !hwrite && haddr < 12'h100
   |=> hrdata[31:8] == 24'h0) else $error("reserved bits not zero");
take_pulse_a: assert property (cpu_take |=> !cpu_take) else $error("take longer than one cycle");
vector_map_a: assert property (cpu_take |-> cpu_vector == {cpu_trap_number, 2'b00})
   else $error("vector not four times number");
trap_entry_a: assert property (trap_event != 8'h00 && cpu_level != 4'hF
   |=> cpu_take && cpu_level == 4'hF) else $error("trap not taken at top level");
nmi_number_a: assert property (trap_event == 8'h01 && cpu_level != 4'hF
   |=> cpu_trap_number == 7'h02) else $error("wrong trap number");
grant_above_a: assert property (cpu_take && cpu_level != 4'hF
   |-> cpu_level > $past(cpu_level)) else $error("grant not above level");
trap_block_a: assert property (cpu_level == 4'hF && trap_event == 8'h00 && !service_done
   |=> !cpu_take) else $error("take during trap service");
endmodule
`default_nettype wire

// File: bench/pitc_cpu_model.sv
/* CPU core stand-in: ends each trap service.
 Assumes trap entry shows as take with level F. */
`timescale 1ns/1ps
`default_nettype none
module pitc_cpu_model #(
   parameter DLY = 6
) (
   input wire logic       hclk,
   input wire logic       hresetn,
   input wire logic       cpu_take,
   input wire logic [3:0] cpu_level,
   input wire logic       stall,
   output var logic       service_done
);
   logic       busy;
   logic [7:0] cnt;
   // Stall lets the bench hold a trap routine open
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         busy <= 1'b0;
         cnt <= 8'h00;
         service_done <= 1'b0;
      end else begin
         service_done <= 1'b0;
         if (cpu_take && cpu_level == 4'hF) begin
            busy <= 1'b1;
            cnt <= 8'h00;
         end else if (busy && !stall && cnt >= DLY) begin
            busy <= 1'b0;
            service_done <= 1'b1;
         end else if (busy) begin
            cnt <= cnt + 8'h01;
         end
      end
   end
endmodule
`default_nettype wire

// File: bench/tb_top.sv
/* Register and service tests of pitc_top.
 Assumes zero-wait AHB-Lite slave and CPU model. */
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   localparam N = 35;
   logic          hclk, hresetn, hsel, hwrite, stall;
   logic          hreadyout, hresp, service_done, cpu_take, irq;
   logic [11:0]   haddr;
   logic [1:0]    htrans;
   logic [31:0]   hwdata, hrdata, rd;
   logic [N-1:0]  src_request;
   logic [7:0]    trap_event;
   logic [6:0]    cpu_trap_number;
   logic [8:0]    cpu_vector;
   logic [3:0]    cpu_level;
   integer        errors, checks, takes, t, i;
   pitc_top #(.N(N)) dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(3'b010), .hwdata(hwdata), .hready(hreadyout),
      .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .src_request(src_request),
      .trap_event(trap_event), .service_done(service_done), .cpu_take(cpu_take),
      .cpu_trap_number(cpu_trap_number), .cpu_vector(cpu_vector), .cpu_level(cpu_level), .irq(irq));
   pitc_cpu_model cpu (.hclk(hclk), .hresetn(hresetn), .cpu_take(cpu_take),
      .cpu_level(cpu_level), .stall(stall), .service_done(service_done));
   always #10 hclk = ~hclk;
   always @(posedge hclk) if (cpu_take === 1'b1) takes <= takes + 1;
   ////////////////////////////////////////////////////////////
   task chk(input logic [31:0] seen, input logic [31:0] exp);
      checks = checks + 1;
      if (seen !== exp) begin
         errors = errors + 1;
         $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task bus(input logic w, input logic [11:0] a, input logic [31:0] d);
      hsel <= 1'b1;
      htrans <= 2'b10;
      haddr <= a;
      hwrite <= w;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'b00;
      hwdata <= d;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      rd = hrdata;
   endtask
   task next_take;
      integer k;
      k = takes;
      repeat (60) if (takes == k) @(posedge hclk);
   endtask
   task wrap_up;
      $display("checks=%0d errors=%0d", checks, errors);
      if (errors == 0 && checks > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   initial begin
      #100000;
      errors = errors + 1;
      wrap_up;
   end
   ////////////////////////////////////////////////////////////
   initial begin
      {hclk, hresetn, hsel, hwrite, stall, haddr, htrans, hwdata} = 0;
      {src_request, trap_event, errors, checks, takes} = 0;
      repeat (8) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      chk(cpu_level, 4'hF);
      for (i = 0; i < N; i++) begin
         bus(0, 12'(i * 4), 0);
         chk(rd, 0);
      end
      bus(1, 12'h00C, 32'hFFFFFFFF);
      bus(0, 12'h00C, 0);
      chk(rd, 32'h000000FF);
      bus(1, 12'h00C, 32'h0);
      bus(0, 12'h200, 0);
      chk(rd, 0);
      $display("test registers done");
      // Same level on 5 and 9, group decides
      bus(1, 12'h008, 32'h3C);
      bus(1, 12'h014, 32'h4D);
      bus(1, 12'h024, 32'h4E);
      src_request <= 35'h224;
      @(posedge hclk);
      src_request <= 0;
      bus(0, 12'h008, 0);
      chk(rd, 32'hBC);
      bus(1, 12'h114, 32'h2);
      bus(1, 12'h108, 32'h0);
      next_take;
      chk(cpu_trap_number, 7'h45);
      chk(cpu_vector, 9'h114);
      chk(cpu_level, 4'h3);
      chk(irq, 1'b1);
      bus(0, 12'h024, 0);
      chk(rd, 32'h4E);
      bus(1, 12'h110, 32'h2);
      repeat (2) @(posedge hclk);
      chk(irq, 1'b0);
      bus(1, 12'h108, 32'h2);
      next_take;
      chk(cpu_trap_number, 7'h3A);
      $display("test arbitration done");
      // Trap preempts the level 3 routine
      stall <= 1'b1;
      trap_event <= 8'h02;
      @(posedge hclk);
      trap_event <= 0;
      next_take;
      chk(cpu_trap_number, 7'h04);
      chk(cpu_level, 4'hF);
      t = takes;
      bus(1, 12'h000, 32'h54);
      src_request <= 35'h1;
      @(posedge hclk);
      src_request <= 0;
      trap_event <= 8'h10;
      @(posedge hclk);
      trap_event <= 0;
      repeat (4) @(posedge hclk);
      chk(takes, t);
      bus(0, 12'h100, 0);
      chk(rd, 32'h12);
      stall <= 1'b0;
      next_take;
      chk(cpu_trap_number, 7'h0A);
      next_take;
      chk(cpu_trap_number, 7'h35);
      bus(1, 12'h104, 32'h12);
      bus(0, 12'h100, 0);
      chk(rd, 0);
      $display("test traps done");
      wrap_up;
   end
endmodule
bind pitc_top pitc_top_props u_props (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
   .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hready(hready), .hrdata(hrdata),
   .hreadyout(hreadyout), .hresp(hresp), .trap_event(trap_event), .service_done(service_done),
   .cpu_take(cpu_take), .cpu_trap_number(cpu_trap_number), .cpu_vector(cpu_vector),
   .cpu_level(cpu_level));
`default_nettype wire
